// ### core/cgr_pkg.sv
/*
  Shared constants and types for the chip-level global configuration registers.
  Assumes a single core clock and an index/data access port driven by host logic
  in the same clock domain.
*/
package cgr_pkg;

  // ==========================================================================
  // Register indices
  // ==========================================================================
  localparam logic [7:0] IDX_UNIT_POWER_ENABLE       = 8'h22;
  localparam logic [7:0] IDX_AUTO_POWER_MANAGE       = 8'h23;
  localparam logic [7:0] IDX_CLOCK_AND_DECODE        = 8'h24;
  localparam logic [7:0] IDX_RESERVED_VENDOR_A       = 8'h25;
  localparam logic [7:0] IDX_CONFIG_PORT_ADDR_LOW    = 8'h26;
  localparam logic [7:0] IDX_CONFIG_PORT_ADDR_HIGH   = 8'h27;
  localparam logic [7:0] IDX_RESERVED_GAP            = 8'h28;
  localparam logic [7:0] IDX_RESERVED_VENDOR_B       = 8'h29;
  localparam logic [7:0] IDX_VENDOR_TEST_F           = 8'h2a;
  localparam logic [7:0] IDX_VENDOR_TEST_D           = 8'h2b;
  localparam logic [7:0] IDX_TEST_AND_KBC_RESET      = 8'h2c;
  localparam logic [7:0] IDX_VENDOR_TEST_A           = 8'h2d;
  localparam logic [7:0] IDX_VENDOR_TEST_B           = 8'h2e;
  localparam logic [7:0] IDX_VENDOR_TEST_C           = 8'h2f;

  // ==========================================================================
  // Field positions and writable masks
  // ==========================================================================
  localparam int         BIT_FLOPPY_CONTROLLER = 0;
  localparam int         BIT_PARALLEL_PORT     = 3;
  localparam int         BIT_SERIAL_PORT1      = 4;
  localparam int         BIT_SERIAL_PORT2      = 5;
  localparam int         BIT_PLL_OFF           = 1;
  localparam int         BIT_OSC_LSB           = 2;
  localparam int         BIT_ADDR16            = 6;
  localparam int         BIT_KBC_RESET         = 6;
  localparam logic [7:0] MASK_UNIT_BITS        = 8'h39;
  localparam logic [7:0] MASK_CLOCK_DECODE     = 8'h4e;
  localparam logic [7:0] MASK_ADDR_LOW         = 8'hfe;
  localparam logic [1:0] OSC_STOPPED           = 2'h3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]  RST_UNIT_POWER_ENABLE = 8'h00;
  localparam logic [7:0]  RST_AUTO_POWER_MANAGE = 8'h00;
  localparam logic [7:0]  RST_CLOCK_AND_DECODE  = 8'h04;
  localparam logic [7:0]  RST_CONFIG_ADDR_HIGH  = 8'h00;
  localparam logic [7:0]  RST_TEST              = 8'h00;
  localparam logic [15:0] RST_CFG_BASE_STRAP_LO = 16'h002e;
  localparam logic [15:0] RST_CFG_BASE_STRAP_HI = 16'h004e;
  localparam int          NUM_TEST_REGS         = 6;

  // ==========================================================================
  // Access request carried from the index/data port logic
  // ==========================================================================
  typedef struct packed {
    logic       index_wr;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] wdata;
  } cgr_acc_t;

  // Reset sources, each a one-cycle or level request from same-clock logic.
  typedef struct packed {
    logic main_por;
    logic stby_por;
    logic host_rst;
    logic soft_rst;
  } cgr_rst_src_t;

endpackage

// ### core/cgr_addr_match.sv
/*
  Host I/O address qualifier for the configuration port.
  Assumes the host address is sampled in the core clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module cgr_addr_match
  import cgr_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int SHORT_W = 12
) (
  // Clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  // Compare inputs
  input  wire logic [ADDR_W-1:0] i_base,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_qual16,
  // Result
  output logic                   o_hit
);

  // ==========================================================================
  // Qualified compare
  // ==========================================================================
  // Only the low address bits are compared in short mode, so aliases appear.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_hit <= 1'b0;
    end else if (i_ce) begin
      if (i_qual16) begin
        o_hit <= (i_addr == i_base);
      end else begin
        o_hit <= (i_addr[SHORT_W-1:0] == i_base[SHORT_W-1:0]);
      end
    end
  end

endmodule
`default_nettype wire

// ### core/cgr_global_regs.sv
/*
  Chip-level global configuration registers, indices 0x22 to 0x2f, reached
  through an index/data port while the chip is in configuration mode.
  Assumes all access strobes and reset sources come from same-clock logic;
  only the address strap arrives from a pin and is synchronised here.
*/
//
// Contract
// - Unit power bits 0,3,4,5 enable floppy, parallel, serial1, serial2.
// - Auto power management bits use the same positions; 1 turns on.
// - Power management bits 7:6 always read zero.
// - Clock register bit 1 high shuts the PLL off.
// - Oscillator field 11 stops oscillator and baud clock, else running.
// - Clock register bit 6 selects 16-bit, else 12-bit address compare.
// - Low address register holds bits 7:1; bit 0 is always zero.
// - High address register holds bits 15:8; any even address allowed.
// - Configuration port moves at once when high byte is written.
// - Configuration address resets only on host reset or main POR.
// - Default port address is 0x02e with strap low, 0x04e high.
// - Keyboard reset bit 6 high holds keyboard core in reset.
// - Reserved indices ignore writes and read zero.
// - Registers are reached by index and data port in config mode.
`timescale 1ns/1ns
`default_nettype none
module cgr_global_regs
  import cgr_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock, reset, enable
  input  wire logic               I_CORE_CLK,
  input  wire logic               I_RESET_N,
  input  wire logic               I_CE,
  // Reset sources
  input  wire cgr_rst_src_t       I_RST_SRC,
  // Index/data access
  input  wire logic               I_CFG_MODE,
  input  wire cgr_acc_t           I_ACC,
  output logic [7:0]              O_RDATA,
  // Address strap pin and host address
  input  wire logic               I_ADDR_STRAP,
  input  wire logic [ADDR_W-1:0]  I_HOST_ADDR,
  output logic                    O_CFG_HIT,
  output logic [ADDR_W-1:0]       O_CFG_BASE,
  // Unit controls
  output logic [3:0]              O_UNIT_POWER,
  output logic [3:0]              O_AUTO_PM,
  output logic                    O_PLL_OFF,
  output logic                    O_OSC_OFF,
  output logic                    O_BAUD_CLK_EN,
  output logic                    O_KBC_RESET
);

  // ==========================================================================
  // Reset grouping
  // ==========================================================================
  logic rst_por;
  logic rst_host;
  logic rst_soft;
  assign rst_por  = !I_RESET_N || I_RST_SRC.main_por || I_RST_SRC.stby_por;
  assign rst_host = rst_por || I_RST_SRC.host_rst;
  assign rst_soft = rst_host || I_RST_SRC.soft_rst;
  logic rst_addr;
  assign rst_addr = !I_RESET_N || I_RST_SRC.main_por || I_RST_SRC.host_rst;

  // ==========================================================================
  // Strap synchroniser
  // ==========================================================================
  logic strap_meta;
  logic strap_sync;
  // The synchroniser keeps running through reset, so the strap level has
  // settled by the last reset cycle, which loads the default address.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_CE) begin
      strap_meta <= I_ADDR_STRAP;
      strap_sync <= strap_meta;
    end
  end

  // ==========================================================================
  // Index register and access decode
  // ==========================================================================
  logic [7:0] index;
  logic       wr_en;
  logic       rd_en;
  assign wr_en = I_CE && I_CFG_MODE && I_ACC.data_wr;
  assign rd_en = I_CE && I_CFG_MODE && I_ACC.data_rd;

  always_ff @(posedge I_CORE_CLK) begin
    if (rst_soft) begin
      index <= 8'h00;
    end else if (I_CE && I_CFG_MODE && I_ACC.index_wr) begin
      index <= I_ACC.wdata;
    end
  end

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    return idx == want;
  endfunction

  // ==========================================================================
  // Power registers
  // ==========================================================================
  logic [7:0] unit_power_enable;
  logic [7:0] auto_power_manage_enable;
  logic [7:0] clock_and_decode_control;

  always_ff @(posedge I_CORE_CLK) begin
    if (rst_soft) begin
      unit_power_enable <= RST_UNIT_POWER_ENABLE;
    end else if (wr_en && hit(index, IDX_UNIT_POWER_ENABLE)) begin
      unit_power_enable <= I_ACC.wdata & MASK_UNIT_BITS;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (rst_host) begin
      auto_power_manage_enable <= RST_AUTO_POWER_MANAGE;
    end else if (wr_en && hit(index, IDX_AUTO_POWER_MANAGE)) begin
      auto_power_manage_enable <= I_ACC.wdata & MASK_UNIT_BITS;
    end
  end

  // Reserved bits 5:4 are not stored, so a careless write cannot disturb them.
  always_ff @(posedge I_CORE_CLK) begin
    if (rst_host) begin
      clock_and_decode_control <= RST_CLOCK_AND_DECODE;
    end else if (wr_en && hit(index, IDX_CLOCK_AND_DECODE)) begin
      clock_and_decode_control <= I_ACC.wdata & MASK_CLOCK_DECODE;
    end
  end

  // ==========================================================================
  // Configuration port address
  // ==========================================================================
  logic [7:0]        config_port_addr_low;
  logic [7:0]        config_port_addr_high;
  logic [ADDR_W-1:0] cfg_base;
  logic [ADDR_W-1:0] next_default_base;
  assign next_default_base = strap_sync ? RST_CFG_BASE_STRAP_HI[ADDR_W-1:0]
                                        : RST_CFG_BASE_STRAP_LO[ADDR_W-1:0];

  always_ff @(posedge I_CORE_CLK) begin
    if (rst_addr) begin
      config_port_addr_low <= next_default_base[7:0];
    end else if (wr_en && hit(index, IDX_CONFIG_PORT_ADDR_LOW)) begin
      config_port_addr_low <= I_ACC.wdata & MASK_ADDR_LOW;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (rst_addr) begin
      config_port_addr_high <= RST_CONFIG_ADDR_HIGH;
    end else if (wr_en && hit(index, IDX_CONFIG_PORT_ADDR_HIGH)) begin
      config_port_addr_high <= I_ACC.wdata;
    end
  end

  // The live base only changes on the high byte write, so a half-written
  // address never moves the port.
  always_ff @(posedge I_CORE_CLK) begin
    if (rst_addr) begin
      cfg_base <= next_default_base;
    end else if (wr_en && hit(index, IDX_CONFIG_PORT_ADDR_HIGH)) begin
      cfg_base <= ADDR_W'({I_ACC.wdata, config_port_addr_low});
    end
  end

  // ==========================================================================
  // Test registers
  // ==========================================================================
  logic [7:0] test_regs [NUM_TEST_REGS];
  localparam logic [7:0] TEST_IDX [NUM_TEST_REGS] = '{
    IDX_VENDOR_TEST_F, IDX_VENDOR_TEST_D, IDX_TEST_AND_KBC_RESET,
    IDX_VENDOR_TEST_A, IDX_VENDOR_TEST_B, IDX_VENDOR_TEST_C
  };

  // Writes are kept as stored values; they steer nothing but the keyboard reset.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TEST_REGS; gi++) begin : g_test
      always_ff @(posedge I_CORE_CLK) begin
        if (rst_por) begin
          test_regs[gi] <= RST_TEST;
        end else if (wr_en && hit(index, TEST_IDX[gi])) begin
          test_regs[gi] <= I_ACC.wdata;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (index)
      IDX_UNIT_POWER_ENABLE:     next_rdata = unit_power_enable;
      IDX_AUTO_POWER_MANAGE:     next_rdata = auto_power_manage_enable;
      IDX_CLOCK_AND_DECODE:      next_rdata = clock_and_decode_control;
      IDX_CONFIG_PORT_ADDR_LOW:  next_rdata = config_port_addr_low;
      IDX_CONFIG_PORT_ADDR_HIGH: next_rdata = config_port_addr_high;
      IDX_VENDOR_TEST_F:         next_rdata = test_regs[0];
      IDX_VENDOR_TEST_D:         next_rdata = test_regs[1];
      IDX_TEST_AND_KBC_RESET:    next_rdata = test_regs[2];
      IDX_VENDOR_TEST_A:         next_rdata = test_regs[3];
      IDX_VENDOR_TEST_B:         next_rdata = test_regs[4];
      IDX_VENDOR_TEST_C:         next_rdata = test_regs[5];
      default:                   next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (rst_soft) begin
      O_RDATA <= 8'h00;
    end else if (rd_en) begin
      O_RDATA <= next_rdata;
    end
  end

  // ==========================================================================
  // Control outputs
  // ==========================================================================
  logic [1:0] osc_field;
  assign osc_field = clock_and_decode_control[BIT_OSC_LSB+1:BIT_OSC_LSB];

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESET_N) begin
      O_UNIT_POWER  <= 4'h0;
      O_AUTO_PM     <= 4'h0;
      O_PLL_OFF     <= 1'b0;
      O_OSC_OFF     <= 1'b0;
      O_BAUD_CLK_EN <= 1'b1;
      O_KBC_RESET   <= 1'b0;
      O_CFG_BASE    <= RST_CFG_BASE_STRAP_LO[ADDR_W-1:0];
    end else if (I_CE) begin
      O_UNIT_POWER  <= {unit_power_enable[BIT_SERIAL_PORT2],
                        unit_power_enable[BIT_SERIAL_PORT1],
                        unit_power_enable[BIT_PARALLEL_PORT],
                        unit_power_enable[BIT_FLOPPY_CONTROLLER]};
      O_AUTO_PM     <= {auto_power_manage_enable[BIT_SERIAL_PORT2],
                        auto_power_manage_enable[BIT_SERIAL_PORT1],
                        auto_power_manage_enable[BIT_PARALLEL_PORT],
                        auto_power_manage_enable[BIT_FLOPPY_CONTROLLER]};
      O_PLL_OFF     <= clock_and_decode_control[BIT_PLL_OFF];
      O_OSC_OFF     <= (osc_field == OSC_STOPPED);
      O_BAUD_CLK_EN <= (osc_field != OSC_STOPPED);
      O_KBC_RESET   <= test_regs[2][BIT_KBC_RESET];
      O_CFG_BASE    <= cfg_base;
    end
  end

  // ==========================================================================
  // Host address qualification
  // ==========================================================================
  cgr_addr_match #(
    .ADDR_W  (ADDR_W),
    .SHORT_W (12)
  ) u_addr_match (
    .i_clk    (I_CORE_CLK),
    .i_rst_n  (I_RESET_N),
    .i_ce     (I_CE),
    .i_base   (cfg_base),
    .i_addr   (I_HOST_ADDR),
    .i_qual16 (clock_and_decode_control[BIT_ADDR16]),
    .o_hit    (O_CFG_HIT)
  );

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);

  a_pm_top_zero: assert property (auto_power_manage_enable[7:6] == 2'h0)
    else $error("power management reserved bits not zero");

  a_addr_even: assert property (config_port_addr_low[0] == 1'b0 && cfg_base[0] == 1'b0)
    else $error("configuration address is odd");

  a_base_moves: assert property (
    wr_en && hit(index, IDX_CONFIG_PORT_ADDR_HIGH) && !rst_addr
    |=> cfg_base == {$past(I_ACC.wdata), $past(config_port_addr_low)})
    else $error("base did not move on high byte write");

  a_base_held: assert property (
    !rst_addr && !(wr_en && hit(index, IDX_CONFIG_PORT_ADDR_HIGH))
    |=> $stable(cfg_base))
    else $error("base changed without high byte write");

  a_addr_default: assert property (
    rst_addr |=> cfg_base == ($past(strap_sync) ? RST_CFG_BASE_STRAP_HI[ADDR_W-1:0]
                                                : RST_CFG_BASE_STRAP_LO[ADDR_W-1:0]))
    else $error("wrong default configuration address");

  a_osc_decode: assert property (
    I_CE |=> O_OSC_OFF == ($past(osc_field) == OSC_STOPPED)
                      && O_BAUD_CLK_EN == !O_OSC_OFF)
    else $error("oscillator decode mismatch");

  a_pll_follow: assert property (
    I_CE |=> O_PLL_OFF == $past(clock_and_decode_control[BIT_PLL_OFF]))
    else $error("PLL control mismatch");

  a_kbc_reset: assert property (
    I_CE |=> O_KBC_RESET == $past(test_regs[2][BIT_KBC_RESET]))
    else $error("keyboard reset mismatch");

  a_rsvd_read: assert property (
    rd_en && !rst_soft && (index < IDX_UNIT_POWER_ENABLE || index > IDX_VENDOR_TEST_C
      || index == IDX_RESERVED_VENDOR_A || index == IDX_RESERVED_GAP
      || index == IDX_RESERVED_VENDOR_B) |=> O_RDATA == 8'h00)
    else $error("reserved index read not zero");

  a_no_cfg_write: assert property (
    !I_CFG_MODE && !rst_soft |=> $stable(unit_power_enable))
    else $error("register written outside configuration mode");

  a_soft_keep: assert property (
    I_RST_SRC.soft_rst && !rst_host && !wr_en |=> $stable(clock_and_decode_control)
      && $stable(cfg_base))
    else $error("soft reset disturbed a protected register");

endmodule
`default_nettype wire

// ### testbench/cgr_global_regs_test.sv
/*
  Self-checking bench for the chip-level global configuration registers.
  Assumes one 50 MHz core clock, same-clock access strobes and reset sources.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module cgr_global_regs_test;
  import cgr_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic         core_clk, reset_n, ce, cfg_mode, strap, hit;
  logic         pll_off, osc_off, baud_en, kbc_reset;
  cgr_rst_src_t rst_src;
  cgr_acc_t     acc_in;
  logic [15:0]  host_addr, cfg_base, base;
  logic [7:0]   rdata;
  logic [3:0]   unit_power, auto_pm;
  logic [7:0]   mir [16];
  logic [31:0]  lfsr;
  int           error_cnt, total_checks;

  cgr_global_regs u_cgr_global_regs (
    .I_CORE_CLK(core_clk), .I_RESET_N(reset_n), .I_CE(ce), .I_RST_SRC(rst_src),
    .I_CFG_MODE(cfg_mode), .I_ACC(acc_in), .O_RDATA(rdata), .I_ADDR_STRAP(strap),
    .I_HOST_ADDR(host_addr), .O_CFG_HIT(hit), .O_CFG_BASE(cfg_base),
    .O_UNIT_POWER(unit_power), .O_AUTO_PM(auto_pm), .O_PLL_OFF(pll_off),
    .O_OSC_OFF(osc_off), .O_BAUD_CLK_EN(baud_en), .O_KBC_RESET(kbc_reset));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // Bits that keep what was written; reserved places keep nothing.
  function automatic logic [7:0] wmask(input logic [7:0] idx);
    case (idx)
      8'h22, 8'h23: return MASK_UNIT_BITS;
      8'h24: return MASK_CLOCK_DECODE;
      8'h26: return MASK_ADDR_LOW;
      8'h27, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  task automatic acc(input logic iw, input logic dw, input logic dr, input logic [7:0] d);
    @(posedge core_clk);
    acc_in <= '{iw, dw, dr, d};
    @(posedge core_clk);
    acc_in <= '0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc(1'b1, 1'b0, 1'b0, idx);
    acc(1'b0, 1'b1, 1'b0, d);
    if (idx inside {[8'h22:8'h2f]}) mir[4'(idx - 8'h22)] = d & wmask(idx);
    if (idx == IDX_CONFIG_PORT_ADDR_HIGH) base = {mir[5], mir[4]};
  endtask

  task automatic rd(input logic [7:0] idx);
    logic [7:0] ex;
    ex = (idx inside {[8'h22:8'h2f]}) ? mir[4'(idx - 8'h22)] : 8'h00;
    acc(1'b1, 1'b0, 1'b0, idx);
    acc(1'b0, 1'b0, 1'b1, 8'h00);
    @(posedge core_clk);
    #1;
    `CHK("rdata", ex, rdata)
  endtask

  task automatic outs;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("unit_power", {mir[0][5], mir[0][4], mir[0][3], mir[0][0]}, unit_power)
    `CHK("auto_pm", {mir[1][5], mir[1][4], mir[1][3], mir[1][0]}, auto_pm)
    `CHK("pll_off", mir[2][1], pll_off)
    `CHK("osc_off", mir[2][3:2] == OSC_STOPPED, osc_off)
    `CHK("baud_en", mir[2][3:2] != OSC_STOPPED, baud_en)
    `CHK("kbc_reset", mir[10][6], kbc_reset)
    `CHK("cfg_base", base, cfg_base)
  endtask

  task automatic hit_chk(input logic [15:0] a);
    logic ex;
    ex = mir[2][6] ? (a == base) : (a[11:0] == base[11:0]);
    @(posedge core_clk);
    host_addr <= a;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("cfg_hit", ex, hit)
  endtask

  task automatic do_reset(input logic s);
    @(posedge core_clk);
    strap   <= s;
    reset_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    foreach (mir[i]) mir[i] = 8'h00;
    mir[2] = RST_CLOCK_AND_DECODE;
    base = s ? RST_CFG_BASE_STRAP_HI : RST_CFG_BASE_STRAP_LO;
    mir[4] = base[7:0];
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  initial begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    report_and_stop();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    logic [7:0] idx, d;
    reset_n = 1'b0; ce = 1'b1; cfg_mode = 1'b1; strap = 1'b0; rst_src = '0;
    acc_in = '0; host_addr = 16'h0000; lfsr = 32'h7ad49f7c;
    error_cnt = 0; total_checks = 0;
    do_reset(1'b0);
    for (int i = 8'h22; i <= 8'h2f; i++) rd(8'(i));
    outs();
    $display("test reset_values done");
    for (int v = 0; v < 4; v++) begin
      wr(IDX_CLOCK_AND_DECODE, 8'h42 | 8'(v << 2));
      outs();
    end
    $display("test clock_field done");
    wr(IDX_CLOCK_AND_DECODE, 8'h40);
    wr(IDX_CONFIG_PORT_ADDR_LOW, 8'h61);
    outs();
    wr(IDX_CONFIG_PORT_ADDR_HIGH, 8'hc3);
    outs();
    hit_chk(base);
    hit_chk(base ^ 16'h1000);
    hit_chk(base ^ 16'h0001);
    wr(IDX_CLOCK_AND_DECODE, 8'h00);
    hit_chk(base ^ 16'h1000);
    $display("test relocate done");
    for (int n = 0; n < 40; n++) begin
      lfsr = next_rand(lfsr);
      case (lfsr[2:0])
        3'd0: idx = 8'h22; 3'd1: idx = 8'h23; 3'd2: idx = 8'h24; 3'd3: idx = 8'h26;
        3'd4: idx = 8'h27; 3'd5: idx = 8'h25; 3'd6: idx = 8'h28; default: idx = 8'h29;
      endcase
      d = lfsr[15:8];
      if (idx == IDX_CLOCK_AND_DECODE) d = d & 8'hcf;
      wr(idx, d);
      rd(idx);
      outs();
      hit_chk(base ^ {lfsr[17:16], 14'h0000});
    end
    $display("test random_access done");
    wr(IDX_TEST_AND_KBC_RESET, 8'h40);
    outs();
    wr(IDX_TEST_AND_KBC_RESET, 8'h00);
    outs();
    $display("test kbc_reset done");
    for (int k = 0; k < 2; k++) begin
      wr(IDX_UNIT_POWER_ENABLE, 8'h00);
      if (k == 0) cfg_mode <= 1'b0;
      else ce <= 1'b0;
      acc(1'b1, 1'b0, 1'b0, IDX_UNIT_POWER_ENABLE);
      acc(1'b0, 1'b1, 1'b0, 8'hff);
      cfg_mode <= 1'b1;
      ce <= 1'b1;
      rd(IDX_UNIT_POWER_ENABLE);
    end
    $display("test refused_access done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h22, 8'hff);
      wr(8'h23, 8'hff);
      wr(8'h24, 8'h42);
      wr(8'h2c, 8'h40);
      wr(8'h26, 8'ha0);
      wr(8'h27, 8'h12);
      @(posedge core_clk);
      rst_src <= cgr_rst_src_t'(4'(1 << s));
      @(posedge core_clk);
      rst_src <= '0;
      mir[0] = 8'h00;
      if (s > 0) begin
        mir[1] = 8'h00;
        mir[2] = RST_CLOCK_AND_DECODE;
      end
      if (s == 1 || s == 3) begin
        base = RST_CFG_BASE_STRAP_LO;
        mir[4] = base[7:0];
        mir[5] = 8'h00;
      end
      if (s > 1) for (int i = 8; i < 14; i++) mir[i] = 8'h00;
      outs();
      rd(IDX_CONFIG_PORT_ADDR_LOW);
      rd(IDX_TEST_AND_KBC_RESET);
    end
    $display("test reset_sources done");
    do_reset(1'b1);
    outs();
    rd(IDX_CONFIG_PORT_ADDR_LOW);
    $display("test strap_high done");
    report_and_stop();
  end
endmodule
`default_nettype wire
